/* File: hw/wwdt_pkg.sv */
package wwdt_pkg;

    // register word addresses on the plain register port
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 32;
    localparam logic [3:0]  ADDR_CONFIG     = 4'h0;
    localparam logic [3:0]  ADDR_RESET_CTRL = 4'h1;
    localparam logic [3:0]  ADDR_COUNT      = 4'h2;
    localparam logic [3:0]  ADDR_POWER      = 4'h3;

    // watchdog_config_word field layout
    localparam int          CFG_W           = 10;
    localparam int          CFG_POST_LSB    = 0;
    localparam int          CFG_POST_W      = 4;
    localparam int          CFG_PRE_BIT     = 4;
    localparam int          CFG_EN_LSB      = 5;
    localparam int          CFG_WINDOW_DISABLE_BIT  = 7;
    localparam int          CFG_WIN_LSB     = 8;
    localparam logic [9:0]  CFG_RESET       = 10'h3FF;

    // reset_control_register bit positions
    localparam int          RC_IDLE_BIT     = 2;
    localparam int          RC_SLEEP_BIT    = 3;
    localparam int          RC_TIMEOUT_BIT  = 4;
    localparam int          RC_SWEN_BIT     = 5;

    // prescaler widths and divide ratios
    localparam int          PRE_W           = 7;
    localparam int          POST_W          = 15;
    localparam int          ELAPSED_W       = PRE_W + POST_W;
    localparam logic [6:0]  PRE_LIMIT_SHORT = 7'h1F;
    localparam logic [6:0]  PRE_LIMIT_LONG  = 7'h7F;
    localparam logic [22:0] PRE_DIV_SHORT   = 23'h000020;
    localparam logic [22:0] PRE_DIV_LONG    = 23'h000080;

    // watchdog_enable_field codes
    localparam logic [1:0]  EN_OFF          = 2'h0;
    localparam logic [1:0]  EN_ACTIVE_ONLY  = 2'h1;
    localparam logic [1:0]  EN_SOFTWARE     = 2'h2;
    localparam logic [1:0]  EN_ALWAYS       = 2'h3;

    // window_size_select codes
    localparam logic [1:0]  WIN_75          = 2'h0;
    localparam logic [1:0]  WIN_50          = 2'h1;
    localparam logic [1:0]  WIN_37          = 2'h2;
    localparam logic [1:0]  WIN_25          = 2'h3;

    // oscillator pin synchroniser depth
    localparam int          SYNC_STAGES     = 3;

    typedef enum logic [1:0] {
        WWDT_ACTIVE,
        WWDT_SLEEP,
        WWDT_IDLE
    } wwdt_power_t;

endpackage : wwdt_pkg

/* File: hw/wwdt_tick_if.sv */
`timescale 1ns/1ps
// carries the oscillator enable down and the clock ticks back up
interface wwdt_tick_if;
    logic osc_enable;
    logic tick;

    modport src  (input  osc_enable, output tick);
    modport sink (output osc_enable, input  tick);
endinterface : wwdt_tick_if

/* File: hw/wwdt_low_power_rc_clock_sync.sv */
`timescale 1ns/1ps
module wwdt_low_power_rc_clock_sync
    import wwdt_pkg::*;
#(
    parameter int STAGES = SYNC_STAGES
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic low_power_rc_clock,
    wwdt_tick_if.src  tick_port
);

    logic [STAGES-1:0] sync_q;
    logic              agreed_level;

    // three-stage synchroniser; first stage only feeds the second
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_q <= '0;
        end else begin
            sync_q <= {sync_q[STAGES-2:0], low_power_rc_clock};
        end
    end

    // level moves only once the last two stages agree, filters glitches
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            agreed_level <= 1'b0;
        end else if (sync_q[STAGES-1] == sync_q[STAGES-2]) begin
            agreed_level <= sync_q[STAGES-1];
        end
    end

    // one tick per rising edge; a stopped oscillator yields none
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_port.tick <= 1'b0;
        end else begin
            tick_port.tick <= tick_port.osc_enable & ~agreed_level
                              & sync_q[STAGES-1] & sync_q[STAGES-2];
        end
    end

endmodule : wwdt_low_power_rc_clock_sync

/* File: hw/wwdt_top.sv */
`timescale 1ns/1ps
// Behaviour
// [RL1] counts low-power RC clock edges; enabling also switches oscillator on
// [RL2] prescaler divides low-power clock by 32 or by 128
// [RL3] postscaler divides prescaler output, sixteen ratios 1:1 to 1:32768
// [RL4] each postscale code step doubles the ratio, code 0 is 1:1
// [RL5] prescale select one means divide by 128, zero by 32
// [RL6] counters clear on device reset and on completed clock switch
// [RL7] counters clear on power-save entry and again on exit
// [RL8] clear-watchdog instruction zeroes count, prescaler and postscaler
// [RL9] enabled watchdog keeps counting in sleep and idle; with enable field 01 the code stops it in both
// [RL10] time-out in sleep or idle wakes device without reset
// [RL11] sleep and idle flags stay set after wake until software clears
// [RL12] enable field 11 runs always, software enable ignored
// [RL13] enable field 10 runs only while software enable bit set
// [RL14] field 01 runs only while active; field 00 disables everything
// [RL15] software enable bit cleared by any device reset
// [RL16] time-out sets sticky time-out flag until software clears it
// [RL17] window-disable bit zero gives windowed, one non-windowed mode
// [RL18] software clears only inside window chosen by window size select
// [RL19] window codes 11,10,01,00 give 25, 37.5, 50, 75 percent
// [RL20] time-out in normal execution requests device reset, sets flag
// [RL21] windowed clear before window opens requests device reset
module wwdt_top
    import wwdt_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              low_power_rc_clock,
    output logic                   low_power_rc_enable,
    input  wire logic              clear_watchdog_instruction,
    input  wire logic              power_save_instruction,
    input  wire logic              power_save_idle,
    input  wire logic              clock_switch_done,
    input  wire logic              wake_request,
    output logic                   device_reset_request,
    output logic                   wake_pulse,
    output logic                   core_sleeping,
    output logic                   core_idling
);

    // configuration word and reset-control state
    logic [CFG_W-1:0]     watchdog_config_word;
    logic                 software_watchdog_enable;
    logic                 timeout_flag;
    logic                 sleep_flag;
    logic                 idle_flag;
    wwdt_power_t          power_mode;

    // counters
    logic [PRE_W-1:0]     pre_cnt;
    logic [POST_W-1:0]    post_cnt;

    // decoded configuration
    logic [3:0]           postscale_select;
    logic                 prescale_select;
    logic [1:0]           watchdog_enable_field;
    logic                 window_disable;
    logic [1:0]           window_size_select;

    // derived control
    logic                 running;
    logic                 low_power_rc_clock_tick;
    logic [PRE_W-1:0]     pre_limit;
    logic [POST_W-1:0]    post_limit;
    logic                 pre_wrap;
    logic                 timeout;

    // window arithmetic
    logic [ELAPSED_W:0]   elapsed;
    logic [ELAPSED_W:0]   period;
    logic [ELAPSED_W:0]   closed_span;

    // instruction and bus events
    logic                 in_active;
    logic                 clear_exec;
    logic                 save_enter;
    logic                 save_exit;
    logic                 window_fault;
    logic                 counters_clear;
    logic                 wr_config;
    logic                 wr_reset_ctrl;

    wwdt_tick_if tick_bus ();

    // oscillator pin sampled into sys_clk, enable passed down
    wwdt_low_power_rc_clock_sync #(
        .STAGES             (SYNC_STAGES)
    ) u_low_power_rc_clock_sync (
        .sys_clk            (sys_clk),
        .rst_b              (rst_b),
        .low_power_rc_clock (low_power_rc_clock),
        .tick_port          (tick_bus.src)
    );

    // decides whether the watchdog runs in the present state
    function automatic logic run_decode(
        input logic [1:0]  en_field,
        input logic        sw_en,
        input wwdt_power_t mode
    );
        logic result;
        result = 1'b0;

        unique case (en_field)
            EN_ALWAYS:      result = 1'b1;                   // [RL12]
            EN_SOFTWARE:    result = sw_en;                  // [RL13]
            EN_ACTIVE_ONLY: result = (mode == WWDT_ACTIVE);  // [RL14]
            EN_OFF:         result = 1'b0;                   // [RL14]
        endcase
        return result;
    endfunction : run_decode

    // portion of the period in which a clear is still too early
    function automatic logic [ELAPSED_W:0] closed_decode(
        input logic [1:0]           win_code,
        input logic [ELAPSED_W:0]   full
    );
        logic [ELAPSED_W:0] span;
        span = '0;

        unique case (win_code)
            WIN_25: span = full - (full >> 2);               // [RL19]
            WIN_37: span = (full >> 1) + (full >> 3);        // [RL19]
            WIN_50: span = full >> 1;                        // [RL19]
            WIN_75: span = full >> 2;                        // [RL19]
        endcase
        return span;
    endfunction : closed_decode

    // field slices of the configuration word
    assign postscale_select      = watchdog_config_word[CFG_POST_LSB +: 4];
    assign prescale_select       = watchdog_config_word[CFG_PRE_BIT];
    assign watchdog_enable_field = watchdog_config_word[CFG_EN_LSB +: 2];
    assign window_disable        = watchdog_config_word[CFG_WINDOW_DISABLE_BIT];
    assign window_size_select    = watchdog_config_word[CFG_WIN_LSB +: 2];

    // run decision and oscillator request
    // oscillator on only while counting
    assign in_active   = (power_mode == WWDT_ACTIVE);
    assign running     = run_decode(watchdog_enable_field,
                                    software_watchdog_enable,
                                    power_mode);               // [RL9]
    assign low_power_rc_enable = running;                     // [RL1]
    assign tick_bus.osc_enable = running;                     // [RL1]
    assign low_power_rc_clock_tick   = tick_bus.tick;

    // prescaler and postscaler terminal counts
    // limits sit one below each ratio
    assign pre_limit   = prescale_select ? PRE_LIMIT_LONG
                                         : PRE_LIMIT_SHORT;   // [RL5]
    assign post_limit  = POST_W'((16'h0001 << postscale_select)
                                 - 16'h0001);                 // [RL4]
    assign pre_wrap    = low_power_rc_clock_tick & (pre_cnt == pre_limit);  // [RL2]
    assign timeout     = running & pre_wrap
                         & (post_cnt == post_limit);          // [RL3]

    // elapsed low-power ticks since the last clear, and full period
    assign elapsed = prescale_select
                     ? {1'b0, post_cnt, pre_cnt}
                     : {3'h0, post_cnt, pre_cnt[4:0]};
    assign period  = (prescale_select ? PRE_DIV_LONG : PRE_DIV_SHORT)
                     << postscale_select;
    assign closed_span = closed_decode(window_size_select, period);

    // instruction events; power-save only acts while executing
    assign clear_exec = clear_watchdog_instruction & in_active;
    assign save_enter = power_save_instruction & in_active;
    assign save_exit  = ~in_active & (wake_request | timeout);

    // early clear in windowed mode is a fault
    assign window_fault = running & clear_exec & ~window_disable
                          & (elapsed < closed_span);          // [RL17] [RL21]

    // everything that restarts the count from zero
    // a stopped watchdog sits at zero
    assign counters_clear = clock_switch_done                 // [RL6]
                            | save_enter | save_exit          // [RL7]
                            | clear_exec                      // [RL8]
                            | ~running;

    // register write decode
    assign wr_config     = reg_wr & (reg_addr == ADDR_CONFIG);
    assign wr_reset_ctrl = reg_wr & (reg_addr == ADDR_RESET_CTRL);

    // prescaler counter; clears win over counting
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_cnt <= '0;                                    // [RL6]
        end else if (counters_clear) begin
            pre_cnt <= '0;                                    // [RL7] [RL8]
        end else if (pre_wrap) begin
            pre_cnt <= '0;                                    // [RL2]
        end else if (low_power_rc_clock_tick) begin
            pre_cnt <= pre_cnt + 7'h01;
        end
    end

    // postscaler counter, advanced once per prescaler wrap
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            post_cnt <= '0;                                   // [RL6]
        end else if (counters_clear) begin
            post_cnt <= '0;                                   // [RL7] [RL8]
        end else if (timeout) begin
            post_cnt <= '0;                                   // [RL3]
        end else if (pre_wrap) begin
            post_cnt <= post_cnt + 15'h0001;
        end
    end

    // power mode; a watchdog time-out wakes without a reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            power_mode <= WWDT_ACTIVE;
        end else begin
            unique case (power_mode)
                WWDT_ACTIVE: begin
                    if (save_enter) begin
                        power_mode <= power_save_idle ? WWDT_IDLE
                                                      : WWDT_SLEEP;
                    end
                end
                WWDT_SLEEP,
                WWDT_IDLE: begin
                    if (save_exit) begin
                        power_mode <= WWDT_ACTIVE;            // [RL10]
                    end
                end
                default: begin
                    power_mode <= WWDT_ACTIVE;
                end
            endcase
        end
    end

    // wake and reset request pulses, one cycle each
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_pulse           <= 1'b0;
            device_reset_request <= 1'b0;
        end else begin
            wake_pulse           <= timeout & ~in_active;     // [RL10]
            device_reset_request <= (timeout & in_active)     // [RL20]
                                    | window_fault;           // [RL21]
        end
    end

    // configuration word; software may reprogram it at any time
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            watchdog_config_word <= CFG_RESET;
        end else if (wr_config) begin
            watchdog_config_word <= reg_wdata[CFG_W-1:0];
        end
    end

    // software enable; dead when the enable field is off
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            software_watchdog_enable <= 1'b0;                 // [RL15]
        end else if (watchdog_enable_field == EN_OFF) begin
            software_watchdog_enable <= 1'b0;                 // [RL14]
        end else if (wr_reset_ctrl) begin
            software_watchdog_enable <= reg_wdata[RC_SWEN_BIT];
        end
    end

    // time-out flag: writing zero clears, a same-cycle event wins
    // set wins, so no time-out is lost
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            timeout_flag <= 1'b0;
        end else if (timeout) begin
            timeout_flag <= 1'b1;                             // [RL16] [RL20]
        end else if (wr_reset_ctrl & ~reg_wdata[RC_TIMEOUT_BIT]) begin
            timeout_flag <= 1'b0;                             // [RL16]
        end
    end

    // sleep and idle flags survive wake-up until cleared by software
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_flag <= 1'b0;
            idle_flag  <= 1'b0;
        end else begin
            if (save_enter & ~power_save_idle) begin
                sleep_flag <= 1'b1;                           // [RL11]
            end else if (wr_reset_ctrl & ~reg_wdata[RC_SLEEP_BIT]) begin
                sleep_flag <= 1'b0;                           // [RL11]
            end

            if (save_enter & power_save_idle) begin
                idle_flag <= 1'b1;                            // [RL11]
            end else if (wr_reset_ctrl & ~reg_wdata[RC_IDLE_BIT]) begin
                idle_flag <= 1'b0;                            // [RL11]
            end
        end
    end

    // power state seen by the core
    assign core_sleeping = (power_mode == WWDT_SLEEP);
    assign core_idling   = (power_mode == WWDT_IDLE);

    // read data valid only in the cycle after the strobe, else zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            unique case (reg_addr)
                ADDR_CONFIG: begin
                    reg_rdata[CFG_W-1:0] <= watchdog_config_word;
                end
                ADDR_RESET_CTRL: begin
                    reg_rdata[RC_SWEN_BIT]    <= software_watchdog_enable;
                    reg_rdata[RC_TIMEOUT_BIT] <= timeout_flag;
                    reg_rdata[RC_SLEEP_BIT]   <= sleep_flag;
                    reg_rdata[RC_IDLE_BIT]    <= idle_flag;
                end
                ADDR_COUNT: begin
                    reg_rdata[ELAPSED_W-1:0] <= {post_cnt, pre_cnt};
                end
                ADDR_POWER: begin
                    reg_rdata[2:0] <= {running, core_idling, core_sleeping};
                end
                default: begin
                    reg_rdata <= '0;
                end
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule : wwdt_top

/* File: sim/wwdt_chk.sv */
`timescale 1ns/1ps
module wwdt_chk
    import wwdt_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst_b,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              clear_watchdog_instruction,
    input wire logic              power_save_instruction,
    input wire logic              power_save_idle,
    input wire logic              clock_switch_done,
    input wire logic              device_reset_request,
    input wire logic              wake_pulse,
    input wire logic              core_sleeping,
    input wire logic              core_idling
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    logic [CFG_W-1:0] cfg_shadow;
    wire  logic       awake = !core_sleeping && !core_idling;

    // shadow of the config word
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_shadow <= CFG_RESET;
        end else if (reg_wr && reg_addr == ADDR_CONFIG) begin
            cfg_shadow <= reg_wdata[CFG_W-1:0];
        end
    end

    cfg_back_a: assert property (
        reg_rd && reg_addr == ADDR_CONFIG |=>
        reg_rdata == DATA_W'(cfg_shadow))
        else $error("config readback wrong");
    count_zero_a: assert property (
        (clear_watchdog_instruction && awake || clock_switch_done)
        ##[1:3] reg_rd && reg_addr == ADDR_COUNT |=> reg_rdata == '0)
        else $error("count not cleared");
    sleep_entry_a: assert property (
        power_save_instruction && !power_save_idle && awake |=>
        core_sleeping && !core_idling)
        else $error("sleep not entered");
    idle_entry_a: assert property (
        power_save_instruction && power_save_idle && awake |=>
        core_idling && !core_sleeping)
        else $error("idle not entered");
    wake_src_a: assert property (
        wake_pulse |-> $past(core_sleeping) || $past(core_idling))
        else $error("wake while awake");
    wake_once_a: assert property (
        wake_pulse |=> !wake_pulse)
        else $error("wake pulse too long");
    reset_active_a: assert property (
        device_reset_request |-> !$past(core_sleeping) && !$past(core_idling))
        else $error("reset while asleep");
    reset_once_a: assert property (
        device_reset_request |=> !device_reset_request)
        else $error("reset pulse too long");
    sleep_flag_a: assert property (
        core_sleeping && reg_rd && reg_addr == ADDR_RESET_CTRL |=>
        reg_rdata[RC_SLEEP_BIT])
        else $error("sleep flag lost");
endmodule : wwdt_chk

bind wwdt_top wwdt_chk u_chk (
    .sys_clk,
    .rst_b,
    .reg_addr,
    .reg_wdata,
    .reg_wr,
    .reg_rd,
    .reg_rdata,
    .clear_watchdog_instruction,
    .power_save_instruction,
    .power_save_idle,
    .clock_switch_done,
    .device_reset_request,
    .wake_pulse,
    .core_sleeping,
    .core_idling
);

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb
    import wwdt_pkg::*;
;
    logic              sys_clk;
    logic              rst_b;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              low_power_rc_clock;
    logic              low_power_rc_enable;
    logic              clear_wd;
    logic              psave;
    logic              psave_idle;
    logic              sw_done;
    logic              wake_request;
    logic              device_reset_request;
    logic              wake_pulse;
    logic              core_sleeping;
    logic              core_idling;
    int                fail_count = 0;
    int                tests_run = 0;
    int                rst_seen = 0;
    int                wake_seen = 0;
    int                closed [4] = '{16, 32, 40, 48};

    wwdt_top uut (
        .sys_clk,
        .rst_b,
        .reg_addr,
        .reg_wdata,
        .reg_wr,
        .reg_rd,
        .reg_rdata,
        .low_power_rc_clock,
        .low_power_rc_enable,
        .clear_watchdog_instruction (clear_wd),
        .power_save_instruction     (psave),
        .power_save_idle            (psave_idle),
        .clock_switch_done          (sw_done),
        .wake_request,
        .device_reset_request,
        .wake_pulse,
        .core_sleeping,
        .core_idling
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // one-cycle pulses, counted as they pass
    always @(posedge sys_clk) begin
        if (device_reset_request === 1'b1) rst_seen++;
        if (wake_pulse === 1'b1) wake_seen++;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    // read data stand only in the next cycle
    task automatic rd(input string what, input logic [3:0] a,
                      input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        check(what, reg_rdata, exp);
    endtask : rd

    // 0 clear, 1 sleep, 2 idle, 3 clock switch, 4 wake
    task automatic pulse(input int k);
        @(posedge sys_clk);
        clear_wd     <= (k == 0);
        psave        <= (k == 1) || (k == 2);
        psave_idle   <= (k == 2);
        sw_done      <= (k == 3);
        wake_request <= (k == 4);
        @(posedge sys_clk);
        {clear_wd, psave, sw_done, wake_request} <= 4'h0;
        @(posedge sys_clk);
        #1;
    endtask : pulse

    // pin high and low 4 cycles each, over the 3-flop sync
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            low_power_rc_clock <= 1'b1;
            repeat (4) @(posedge sys_clk);
            low_power_rc_clock <= 1'b0;
            repeat (3) @(posedge sys_clk);
        end
        repeat (6) @(posedge sys_clk);
        #1;
    endtask : ticks

    function automatic logic [31:0] cnt(input int n, input int d);
        return 32'(((n / d) << 7) | (n % d));
    endfunction : cnt

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // hang guard, far above the ~6000 cycles needed
    initial begin
        repeat (40000) @(posedge sys_clk);
        fail_count++;
        test_done();
    end

    initial begin
        {rst_b, reg_wr, reg_rd, low_power_rc_clock} = 4'h0;
        {clear_wd, psave, psave_idle, sw_done, wake_request} = 5'h0;
        reg_addr = '0;
        reg_wdata = '0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        // reset state
        rd("config", ADDR_CONFIG, 32'h000003FF);
        rd("reset ctrl", ADDR_RESET_CTRL, 32'h0);
        rd("unmapped", 4'hA, 32'h0);
        wr(ADDR_RESET_CTRL, 32'h0);
        check("always on", low_power_rc_enable, 1'b1);
        // non-windowed, so any clear is harmless
        wr(ADDR_CONFIG, 32'h3E2);
        pulse(3);
        rd("switch clear", ADDR_COUNT, 32'h0);
        ticks(40);
        rd("count div32", ADDR_COUNT, cnt(40, 32));
        pulse(0);
        rd("clear count", ADDR_COUNT, 32'h0);
        check("no window fault", rst_seen, 0);
        wr(ADDR_CONFIG, 32'h3F2);
        ticks(130);
        rd("count div128", ADDR_COUNT, cnt(130, 128));
        // active time-out, period 64 ticks
        wr(ADDR_CONFIG, 32'h0E1);
        pulse(3);
        ticks(63);
        check("not yet", rst_seen, 0);
        ticks(1);
        check("timeout reset", rst_seen, 1);
        rd("timeout flag", ADDR_RESET_CTRL, 32'h10);
        ticks(64);
        check("second timeout", rst_seen, 2);
        rd("flag sticky", ADDR_RESET_CTRL, 32'h10);
        // sleep: clear on entry, keep counting, wake on time-out
        wr(ADDR_RESET_CTRL, 32'h0);
        ticks(10);
        pulse(1);
        check("sleeping", core_sleeping, 1'b1);
        rd("entry clear", ADDR_COUNT, 32'h0);
        rd("sleep flag", ADDR_RESET_CTRL, 32'h8);
        rd("power", ADDR_POWER, 32'h5);
        ticks(30);
        rd("sleep count", ADDR_COUNT, cnt(30, 32));
        ticks(34);
        check("wake", wake_seen, 1);
        check("no reset", rst_seen, 2);
        check("awake", core_sleeping, 1'b0);
        rd("flags kept", ADDR_RESET_CTRL, 32'h18);
        rd("exit clear", ADDR_COUNT, 32'h0);
        // enable field 01, 00 and 10
        wr(ADDR_CONFIG, 32'h0A2);
        check("01 active", low_power_rc_enable, 1'b1);
        pulse(2);
        check("idling", core_idling, 1'b1);
        check("01 idle", low_power_rc_enable, 1'b0);
        pulse(4);
        check("idle left", core_idling, 1'b0);
        wr(ADDR_CONFIG, 32'h082);
        wr(ADDR_RESET_CTRL, 32'h20);
        rd("swen ignored", ADDR_RESET_CTRL, 32'h0);
        check("00 off", low_power_rc_enable, 1'b0);
        wr(ADDR_CONFIG, 32'h0C2);
        check("10 off", low_power_rc_enable, 1'b0);
        ticks(5);
        rd("10 held", ADDR_COUNT, 32'h0);
        wr(ADDR_RESET_CTRL, 32'h20);
        check("10 on", low_power_rc_enable, 1'b1);
        ticks(5);
        rd("10 runs", ADDR_COUNT, cnt(5, 32));
        // reset in mid-run
        rst_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd("swen reset", ADDR_RESET_CTRL, 32'h0);
        rd("count reset", ADDR_COUNT, 32'h0);
        // each window code, one tick either side
        for (int w = 0; w < 4; w++) begin
            wr(ADDR_CONFIG, 32'h061 | 32'(w << 8));
            pulse(3);
            ticks(closed[w] - 1);
            pulse(0);
            check("early clear", rst_seen, 3 + w);
            pulse(3);
            ticks(closed[w]);
            pulse(0);
            check("open clear", rst_seen, 3 + w);
        end
        rd("fault no flag", ADDR_RESET_CTRL, 32'h0);
        test_done();
    end
endmodule : tb
